// [inc/bias_offset_defs.vh]
// constants for the bias-offset register bank and its correction path
// assumes: included by bare name from each design file that needs it
`ifndef BIAS_OFFSET_DEFS_VH
`define BIAS_OFFSET_DEFS_VH

// register indices; byte address on the bus is four times the index
`define IDX_GYRO_Z_OFFSET_LOWER 12'h0048
`define IDX_GYRO_Z_OFFSET_UPPER 12'h004a
`define IDX_ACCEL_X_OFFSET_LOWER 12'h004c
`define IDX_ACCEL_X_OFFSET_UPPER 12'h004e
`define IDX_ACCEL_Y_OFFSET_LOWER 12'h0050
`define IDX_ACCEL_Y_OFFSET_UPPER 12'h0052
`define IDX_ACCEL_Z_OFFSET_LOWER 12'h0054

// bank shape
`define OFFSET_REG_COUNT 7
`define OFFSET_AXIS_COUNT 4
`define OFFSET_WORD_W 16
`define SAMPLE_W 32
`define PADDR_W 12

// field positions of a 16-bit word in the 32-bit bus word
`define WORD_MSB 15
`define WORD_LSB 0

// reset values
`define RST_OFFSET_WORD 16'h0000
`define RST_BUS_WORD 32'h0000_0000

// saturation limits of the 32-bit twos-complement result
`define SAT_POS 32'h7fff_ffff
`define SAT_NEG 32'h8000_0000

`endif

// [tb/apb_host_model.sv]
// host processor model: APB master of the bank
// assumes: tasks are called just after a rising clock edge
`timescale 1ns/1ps
module apb_host_model (
	input wire CLOCK,
	output logic PSEL = 1'b0,
	output logic PENABLE = 1'b0,
	output logic PWRITE = 1'b0,
	output logic [11:0] PADDR = 12'h0000,
	output logic [31:0] PWDATA = 32'h0000_0000,
	output logic [3:0] PSTRB = 4'hf,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR
);
	// request held until pready is seen at an edge
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PENABLE <= 1'b0;
	endtask
	task idle;
		PSEL <= 1'b0;
		@(posedge CLOCK);
	endtask
endmodule // apb_host_model

// [tb/bias_offset_monitor.sv]
// port checker for the bias-offset register bank
// assumes: bound into bias_offset_bank, one clock, sync reset
`timescale 1ns/1ps
module bias_offset_monitor (
	input wire CLOCK,
	input wire RST,
	input wire CE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	input wire SAMPLE_VALID,
	input wire [31:0] ACCEL_Z_SAMPLE,
	input wire [15:0] ACCEL_Z_UPPER,
	input wire [15:0] ACCEL_Z_LOWER,
	input wire [31:0] ACCEL_Z_CORRECTED,
	input wire [3:0] CORRECTED_VALID
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// 33-bit sum so saturated samples can be left out
	wire [32:0] az_sum = {ACCEL_Z_SAMPLE[31], ACCEL_Z_SAMPLE}
		+ {ACCEL_Z_UPPER[15], ACCEL_Z_UPPER, ACCEL_Z_LOWER};
	wire take = SAMPLE_VALID && CE;
	sequence s_setup; PSEL && !PENABLE && PWRITE && PADDR == 12'h0150;
	endsequence
	sequence s_access; PSEL && PENABLE && CE && PSTRB[1:0] == 2'b11;
	endsequence
	property p_ready; PREADY == CE; endproperty
	property p_valid; take |=> CORRECTED_VALID == 4'hf; endproperty
	property p_quiet; !take |=> CORRECTED_VALID == 4'h0; endproperty
	property p_hold; !take |=> $stable(ACCEL_Z_CORRECTED); endproperty
	property p_upper0; PRDATA[31:16] == 16'h0000; endproperty
	property p_err; PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR;
	endproperty
	property p_low; s_setup ##1 s_access |=>
		ACCEL_Z_LOWER == $past(PWDATA[15:0]); endproperty
	property p_az; take && az_sum[32] == az_sum[31] |=>
		ACCEL_Z_CORRECTED == $past(az_sum[31:0]); endproperty
	a_ready: assert property (p_ready) else $error("ready not equal ce");
	a_valid: assert property (p_valid) else $error("no valid");
	a_quiet: assert property (p_quiet) else $error("stray valid");
	a_hold: assert property (p_hold) else $error("result moved");
	a_upper0: assert property (p_upper0) else $error("upper read bits");
	a_err: assert property (p_err) else $error("no error response");
	a_low: assert property (p_low) else $error("lower word lost");
	a_az: assert property (p_az) else $error("z accel sum");
endmodule // bias_offset_monitor
bind bias_offset_bank bias_offset_monitor mon (.*);

// [tb/test_bias_offset_bank.sv]
// self-checking bench for bias_offset_bank
// assumes: apb_host_model drives the bus, bench drives samples
`timescale 1ns/1ps
`include "bias_offset_defs.vh"
`define CHK(n, x, a) check_count++; \
	if ((a) !== (x)) begin \
		mismatches++; \
		$display("wrong value %s exp %h got %h", n, x, a); \
	end
module test_bias_offset_bank;
	logic CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, SAMPLE_VALID = 1'b0;
	logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
	logic [11:0] PADDR;
	logic [3:0] PSTRB, CORRECTED_VALID;
	logic [15:0] ACCEL_Z_UPPER = 16'hffff, ACCEL_Z_LOWER;
	logic [31:0] PWDATA, PRDATA, r, GYRO_Z_CORRECTED, ACCEL_X_CORRECTED;
	logic [31:0] ACCEL_Y_CORRECTED, ACCEL_Z_CORRECTED;
	logic [31:0] GYRO_Z_SAMPLE = 32'h0000_0064, ACCEL_X_SAMPLE = 32'h0000_0010;
	logic [31:0] ACCEL_Y_SAMPLE = 32'hffff_ffff, ACCEL_Z_SAMPLE = 32'h0001_0000;
	logic [15:0] ofs [7] = '{16'hfffe, 16'hffff, 16'h0000, 16'h0001,
		16'h0000, 16'h8000, 16'h0005};
	int mismatches = 0, check_count = 0;
	always #12.5 CLOCK = ~CLOCK;
	bias_offset_bank DUT (.*);
	apb_host_model host (.*);
	// byte address is four times the register index, which steps by two per word
	function automatic logic [11:0] ra(int i);
		return 12'((`IDX_GYRO_Z_OFFSET_LOWER + 2 * i) * 4);
	endfunction
	task automatic wr(int i, logic [15:0] d);
		host.xfer(1'b1, ra(i), {16'hffff, d}, r, e);
		`CHK("write error", 1'b0, e)
	endtask
	task automatic rd(int i, logic [15:0] d);
		host.xfer(1'b0, ra(i), 32'h0000_0000, r, e);
		`CHK("read data", {16'h0000, d}, r)
	endtask
	task t_reset;
		for (int i = 0; i < 7; i++) rd(i, `RST_OFFSET_WORD);
		host.idle;
		$display("reset values done");
	endtask
	// back-to-back, all 16 bits, junk in the upper bus half
	task t_rw;
		for (int i = 0; i < 7; i++) wr(i, 16'ha5c3 ^ 16'(i));
		for (int i = 0; i < 7; i++) rd(i, 16'ha5c3 ^ 16'(i));
		host.idle;
		`CHK("z accel lower", 16'ha5c5, ACCEL_Z_LOWER)
		$display("read/write done");
	endtask
	task t_err;
		host.xfer(1'b1, 12'h0121, 32'h0000_1234, r, e);
		`CHK("unaligned", 1'b1, e)
		host.xfer(1'b1, 12'h0158, 32'h0000_1234, r, e);
		`CHK("unmapped", 1'b1, e)
		host.xfer(1'b0, 12'h0124, 32'h0000_0000, r, e);
		`CHK("unmapped data", 32'h0000_0000, r)
		rd(0, 16'ha5c3);
		host.idle;
		$display("error responses done");
	endtask
	// negative, positive and saturating offsets in one sample
	task t_sum;
		for (int i = 0; i < 7; i++) wr(i, ofs[i]);
		host.idle;
		SAMPLE_VALID <= 1'b1;
		@(posedge CLOCK);
		SAMPLE_VALID <= 1'b0;
		#1;
		`CHK("valid", 4'hf, CORRECTED_VALID)
		`CHK("gyro z", 32'h0000_0062, GYRO_Z_CORRECTED)
		`CHK("accel x", 32'h0001_0010, ACCEL_X_CORRECTED)
		`CHK("accel y", 32'h8000_0000, ACCEL_Y_CORRECTED)
		`CHK("accel z", 32'h0000_0005, ACCEL_Z_CORRECTED)
		$display("correction done");
	endtask
	// ce low in the access phase stretches it; no write until ce is back
	task t_freeze;
		fork
			wr(6, 16'h0007);
			begin
				@(posedge CLOCK);
				CE <= 1'b0;
				repeat (3) @(posedge CLOCK);
				`CHK("frozen lower", 16'h0005, ACCEL_Z_LOWER)
				CE <= 1'b1;
			end
		join
		host.idle;
		`CHK("thawed lower", 16'h0007, ACCEL_Z_LOWER)
		rd(6, 16'h0007);
		// mid-run reset clears words and results
		RST <= 1'b1;
		@(posedge CLOCK);
		RST <= 1'b0;
		rd(0, `RST_OFFSET_WORD);
		host.idle;
		`CHK("reset result", 32'h0000_0000, GYRO_Z_CORRECTED)
		$display("freeze and reset done");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge CLOCK);
		RST <= 1'b0;
		t_reset;
		t_rw;
		t_err;
		t_sum;
		t_freeze;
		end_sim;
	end
	// hang guard, far beyond the 85 cycles needed
	initial begin
		#100000;
		mismatches++;
		end_sim;
	end
endmodule // test_bias_offset_bank

// [verilog/bias_offset_bank.v]
// user bias-offset register bank with APB access and correction path
// assumes: calibrated samples arrive on CLOCK from the sensor chain;
// the z accelerometer upper word lives in a neighbouring bank
//
// Operation
// - the z gyro lower and upper words form one 32-bit offset applied to the z gyro bias.
// - the x accel lower and upper words form one 32-bit offset applied to the x accel bias.
// - the y accel lower and upper words form one 32-bit offset applied like the x accel one.
// - the z gyro upper register holds all 16 bits of the top half of its offset.
// - the x accel upper register holds all 16 bits of the top half of its offset.
// - the y accel upper register holds all 16 bits of the top half of its offset.
// - the z accel lower register holds all 16 bits of the bottom half of its offset.
// - the upper word scales like the 16-bit output and the pair like the 32-bit output.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "bias_offset_defs.vh"

module bias_offset_bank (
	input wire CLOCK,
	input wire RST,
	input wire CE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	input wire SAMPLE_VALID,
	input wire [31:0] GYRO_Z_SAMPLE,
	input wire [31:0] ACCEL_X_SAMPLE,
	input wire [31:0] ACCEL_Y_SAMPLE,
	input wire [31:0] ACCEL_Z_SAMPLE,
	input wire [15:0] ACCEL_Z_UPPER,
	output wire [15:0] ACCEL_Z_LOWER,
	output wire [31:0] GYRO_Z_CORRECTED,
	output wire [31:0] ACCEL_X_CORRECTED,
	output wire [31:0] ACCEL_Y_CORRECTED,
	output wire [31:0] ACCEL_Z_CORRECTED,
	output wire [3:0] CORRECTED_VALID
);

	// index table, one 12-bit entry per register, entry 0 lowest
	wire [`OFFSET_REG_COUNT*12-1:0] idx_table;
	assign idx_table = {
		`IDX_ACCEL_Z_OFFSET_LOWER,
		`IDX_ACCEL_Y_OFFSET_UPPER,
		`IDX_ACCEL_Y_OFFSET_LOWER,
		`IDX_ACCEL_X_OFFSET_UPPER,
		`IDX_ACCEL_X_OFFSET_LOWER,
		`IDX_GYRO_Z_OFFSET_UPPER,
		`IDX_GYRO_Z_OFFSET_LOWER
	};

	// bus phase qualifiers
	wire setup_ph;
	wire access_ph;
	wire aligned;
	assign setup_ph = PSEL && !PENABLE;
	assign access_ph = PSEL && PENABLE;
	assign aligned = (PADDR[1:0] == 2'b00);

	// register storage, flat: word i at [16*i+15 : 16*i]
	wire [`OFFSET_REG_COUNT*16-1:0] words;
	wire [`OFFSET_REG_COUNT-1:0] hit;

	// frozen clock enable also holds off the bus answer
	assign PREADY = CE;

	// one decoder and one storage word per register
	genvar i;
	generate
		for (i = 0; i < `OFFSET_REG_COUNT; i = i + 1) begin : g_reg
			wire [11:0] idx;
			wire [11:0] byte_addr;
			assign idx = idx_table[12*i+11:12*i];
			assign byte_addr = {idx[9:0], 2'b00};
			assign hit[i] = aligned && (PADDR == byte_addr);
			// all sixteen bits writable and held
			offset_reg u_word (
				.clk(CLOCK),
				.rst(RST),
				.ce(CE),
				.wr_en(access_ph && PWRITE && hit[i]),
				.strb(PSTRB[1:0]),
				.wdata(PWDATA[`WORD_MSB:`WORD_LSB]),
				.q_r(words[16*i+15:16*i])
			);
		end
	endgenerate

	// read mux over the decoded word; nothing selected reads zero
	reg [15:0] rd_word;
	integer k;
	always @* begin
		rd_word = `RST_OFFSET_WORD;
		for (k = 0; k < `OFFSET_REG_COUNT; k = k + 1) begin
			if (hit[k]) begin
				rd_word = words[16*k +: 16];
			end
		end
	end

	// read data and error taken in the setup cycle, shown in access;
	// registering here keeps PRDATA glitch free at zero wait states
	reg [31:0] prdata_r;
	reg pslverr_r;
	always @(posedge CLOCK) begin
		if (RST) begin
			prdata_r <= `RST_BUS_WORD;
			pslverr_r <= 1'b0;
		end else if (CE && setup_ph) begin
			prdata_r <= {16'h0000, rd_word};
			pslverr_r <= ~|hit;
		end
	end

	// error only shown during the access phase
	assign PRDATA = prdata_r;
	assign PSLVERR = pslverr_r && access_ph;

	// neighbour bank needs our half of the z accel pair
	assign ACCEL_Z_LOWER = words[16*6+15:16*6];

	// combined offsets: upper word on top, lower word below, so the
	// upper lsb weighs as the 16-bit output lsb and the pair as 32-bit
	wire [`OFFSET_AXIS_COUNT*32-1:0] offsets;
	assign offsets[31:0] = {words[31:16], words[15:0]};
	assign offsets[63:32] = {words[63:48], words[47:32]};
	assign offsets[95:64] = {words[95:80], words[79:64]};
	assign offsets[127:96] = {ACCEL_Z_UPPER, words[111:96]};

	// calibrated samples per axis, same order as the offsets
	wire [`OFFSET_AXIS_COUNT*32-1:0] samples;
	assign samples = {ACCEL_Z_SAMPLE, ACCEL_Y_SAMPLE, ACCEL_X_SAMPLE,
		GYRO_Z_SAMPLE};

	// corrected results per axis
	wire [`OFFSET_AXIS_COUNT*32-1:0] results;

	// offset added before the result reaches the output registers
	genvar a;
	generate
		for (a = 0; a < `OFFSET_AXIS_COUNT; a = a + 1) begin : g_axis
			offset_adder u_add (
				.clk(CLOCK),
				.rst(RST),
				.ce(CE),
				.in_valid(SAMPLE_VALID),
				.sample(samples[32*a+31:32*a]),
				.offset(offsets[32*a+31:32*a]),
				.result_r(results[32*a+31:32*a]),
				.out_valid_r(CORRECTED_VALID[a])
			);
		end
	endgenerate

	// outputs straight from the adder flip-flops
	assign GYRO_Z_CORRECTED = results[31:0];
	assign ACCEL_X_CORRECTED = results[63:32];
	assign ACCEL_Y_CORRECTED = results[95:64];
	assign ACCEL_Z_CORRECTED = results[127:96];

endmodule // bias_offset_bank

// [verilog/offset_adder.v]
// adds a signed 32-bit offset to a signed 32-bit sample, one stage
// assumes: sample and valid come from logic on the same clock
`timescale 1ns/1ps
`include "bias_offset_defs.vh"

module offset_adder (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire in_valid,
	input wire [31:0] sample,
	input wire [31:0] offset,
	output reg [31:0] result_r,
	output reg out_valid_r
);

	wire [32:0] sum;
	wire ovf;

	// sign-extended sum; overflow when the two top bits differ
	assign sum = {sample[31], sample} + {offset[31], offset};
	assign ovf = sum[32] ^ sum[31];

	// saturate rather than wrap, so a large offset never flips the sign
	always @(posedge clk) begin
		if (rst) begin
			result_r <= `RST_BUS_WORD;
			out_valid_r <= 1'b0;
		end else if (ce) begin
			out_valid_r <= in_valid;
			if (in_valid) begin
				if (ovf) begin
					result_r <= sum[32] ? `SAT_NEG : `SAT_POS;
				end else begin
					result_r <= sum[31:0];
				end
			end
		end
	end

endmodule // offset_adder

// [verilog/offset_reg.v]
// one 16-bit read/write offset word with byte-lane write strobes
// assumes: wr_en already qualified by the bus slave's write decode
`timescale 1ns/1ps
`include "bias_offset_defs.vh"

module offset_reg (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire wr_en,
	input wire [1:0] strb,
	input wire [15:0] wdata,
	output reg [15:0] q_r
);

	// each byte lane written on its own strobe; frozen while ce is low
	always @(posedge clk) begin
		if (rst) begin
			q_r <= `RST_OFFSET_WORD;
		end else if (ce && wr_en) begin
			if (strb[0]) begin
				q_r[7:0] <= wdata[7:0];
			end
			if (strb[1]) begin
				q_r[15:8] <= wdata[15:8];
			end
		end
	end

endmodule // offset_reg
